/* File: inc/osr_map.svh */
/*
  Register offset, field positions, reset values and ramp constants of the output slew ramp control.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef OSR_MAP_SVH
`define OSR_MAP_SVH
`define OSR_CFG_OFFSET 8'h03
`define OSR_RISE_MSB 6
`define OSR_RISE_LSB 4
`define OSR_SHUT_BIT 3
`define OSR_FALL_MSB 2
`define OSR_FALL_LSB 0
`define OSR_CFG_RESET 8'h1c
`define OSR_CFG_RESET_TERM 8'h0c
`define OSR_TICKS_CODE0 40
`define OSR_TICKS_CODE1 20
`define OSR_TICKS_CODE2 10
`define OSR_TICKS_CODE3 8
`define OSR_TICKS_CODE4 4
`define OSR_TICKS_CODE5 2
`define OSR_TICKS_CODE6 1
`define OSR_CFG_WMASK 8'h7f
`define OSR_STEP_MV 10
`define OSR_LSB_UV 2500
`define OSR_STEP_CODES 12'h004
`define OSR_RATE_RESERVED 3'h7
`endif

/* File: inc/osr_pkg.sv */
/*
  Types shared by the output slew ramp control.
  Assumes the map header is on the include path.
*/
package osr_pkg;
  `include "osr_map.svh"
  typedef enum logic [2:0] {
    OSR_OFF,
    OSR_RAMP_UP,
    OSR_HOLDOFF_DONE,
    OSR_REGULATE,
    OSR_RAMP_DOWN
  } osr_state_e;
  typedef logic [11:0] osr_volt_t;
endpackage : osr_pkg

/* File: rtl/osr_step_timer.sv */
/*
  Step timer: divides master clock ticks into one step pulse per programmed step period.
  Assumes master clock ticks arrive synchronous to clk as one-cycle pulses.
*/
module osr_step_timer #(
  parameter int TICK_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic master_tick,
  input wire logic [TICK_W-1:0] ticks_per_step,
  output logic step
);
  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic step;
  } osr_tmr_s;
  osr_tmr_s st_reg;
  osr_tmr_s st_next;

  if (TICK_W < 1) begin : g_bad_width
    $error("osr_step_timer: counter width out of range");
  end

  always_comb begin
    st_next = st_reg;
    st_next.step = 1'b0;
    if (!run) begin
      st_next.cnt = '0;
    end else if (master_tick) begin
      if (st_reg.cnt + TICK_W'(1) >= ticks_per_step) begin
        st_next.cnt = '0;
        st_next.step = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + TICK_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign step = st_reg.step;
endmodule : osr_step_timer

/* File: rtl/osr_ramp_ctrl.sv */
/*
  Output slew ramp control: ramp configuration register, setpoint ramp generator, pre-bias hold-off.
  Assumes a register port of address, write strobe and data synchronous to clk, and a master clock
  tick pulse from the power manager path already synchronous to clk.
*/
`include "osr_map.svh"
module osr_ramp_ctrl #(
  parameter int TICK_W = 16,
  parameter int T_05 = `OSR_TICKS_CODE0,
  parameter int T_1 = `OSR_TICKS_CODE1,
  parameter int T_2 = `OSR_TICKS_CODE2,
  parameter int T_25 = `OSR_TICKS_CODE3,
  parameter int T_5 = `OSR_TICKS_CODE4,
  parameter int T_10 = `OSR_TICKS_CODE5,
  parameter int T_20 = `OSR_TICKS_CODE6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_terminator,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic master_tick,
  input wire logic turn_on,
  input wire logic shutoff_expired,
  input wire osr_pkg::osr_volt_t target_setpoint,
  input wire osr_pkg::osr_volt_t sensed_output,
  output osr_pkg::osr_volt_t setpoint,
  output logic power_stage_en,
  output logic ramp_active,
  output logic shutoff_done
);
  import osr_pkg::*;

  // Every divisor must be at least one and fit the step counter
  if (TICK_W < 1 || TICK_W > 30 || T_05 < 1 || T_1 < 1 || T_2 < 1 || T_25 < 1 || T_5 < 1 || T_10 < 1 ||
      T_20 < 1 || T_05 >= (1 << TICK_W) || T_1 >= (1 << TICK_W) || T_2 >= (1 << TICK_W) ||
      T_25 >= (1 << TICK_W) || T_5 >= (1 << TICK_W) || T_10 >= (1 << TICK_W) ||
      T_20 >= (1 << TICK_W)) begin : g_bad_div
    $error("osr_ramp_ctrl: step divisors out of range");
  end

  typedef struct packed {
    osr_state_e state;
    logic [7:0] cfg;
    logic cfg_init;
    osr_volt_t sp;
    logic pwr;
    logic done;
    logic ramp;
    logic [7:0] rdata;
  } osr_ctl_s;
  osr_ctl_s st_reg;
  osr_ctl_s st_next;

  logic step;
  logic timer_run;
  logic [2:0] rate_sel;
  logic [TICK_W-1:0] ticks_per_step;

  function automatic logic [TICK_W-1:0] rate_ticks(input logic [2:0] code);
    case (code)
      3'h0: rate_ticks = TICK_W'(T_05);
      3'h1: rate_ticks = TICK_W'(T_1);
      3'h2: rate_ticks = TICK_W'(T_2);
      3'h3: rate_ticks = TICK_W'(T_25);
      3'h4: rate_ticks = TICK_W'(T_5);
      3'h5: rate_ticks = TICK_W'(T_10);
      3'h6: rate_ticks = TICK_W'(T_20);
      default: rate_ticks = TICK_W'(T_1);
    endcase
  endfunction : rate_ticks

  // Direction picks its own field
  assign rate_sel = (st_reg.state == OSR_RAMP_DOWN) ?
    st_reg.cfg[`OSR_FALL_MSB:`OSR_FALL_LSB] : st_reg.cfg[`OSR_RISE_MSB:`OSR_RISE_LSB];
  assign ticks_per_step = rate_ticks(rate_sel);
  assign timer_run = (st_reg.state == OSR_RAMP_UP) || (st_reg.state == OSR_RAMP_DOWN);

  osr_step_timer #(
    .TICK_W(TICK_W)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .run(timer_run),
    .master_tick(master_tick),
    .ticks_per_step(ticks_per_step),
    .step(step)
  );

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    // Reset value captured after release
    if (!st_reg.cfg_init) begin
      st_next.cfg_init = 1'b1;
      st_next.cfg = bus_terminator ? `OSR_CFG_RESET_TERM : `OSR_CFG_RESET;
    end
    if (reg_wr && reg_addr == `OSR_CFG_OFFSET) begin
      st_next.cfg = reg_wdata & `OSR_CFG_WMASK;
      st_next.cfg_init = 1'b1;
    end
    st_next.rdata = (reg_addr == `OSR_CFG_OFFSET) ? (st_reg.cfg & `OSR_CFG_WMASK) : 8'h00;
    case (st_reg.state)
      OSR_OFF: begin
        st_next.pwr = 1'b0;
        if (turn_on) begin
          st_next.sp = '0;
          st_next.state = OSR_RAMP_UP;
        end
      end
      OSR_RAMP_UP: begin
        if (shutoff_expired) begin
          st_next.state = OSR_REGULATE;
        end else if (step) begin
          if (target_setpoint - st_reg.sp <= `OSR_STEP_CODES || st_reg.sp >= target_setpoint) begin
            st_next.sp = target_setpoint;
            st_next.state = OSR_HOLDOFF_DONE;
          end else begin
            st_next.sp = st_reg.sp + `OSR_STEP_CODES;
          end
        end
        if (st_reg.sp > sensed_output) begin
          st_next.pwr = 1'b1;
        end
      end
      OSR_HOLDOFF_DONE: begin
        st_next.pwr = 1'b1;
        st_next.state = OSR_REGULATE;
      end
      OSR_REGULATE: begin
        if (shutoff_expired) begin
          if (st_reg.cfg[`OSR_SHUT_BIT]) begin
            st_next.state = OSR_RAMP_DOWN;
          end else begin
            st_next.pwr = 1'b0;
            st_next.sp = '0;
            st_next.done = 1'b1;
            st_next.state = OSR_OFF;
          end
        end
      end
      OSR_RAMP_DOWN: begin
        if (step) begin
          if (st_reg.sp <= `OSR_STEP_CODES) begin
            st_next.sp = '0;
            st_next.pwr = 1'b0;
            st_next.done = 1'b1;
            st_next.state = OSR_OFF;
          end else begin
            st_next.sp = st_reg.sp - `OSR_STEP_CODES;
          end
        end
      end
      default: begin
        st_next.state = OSR_OFF;
      end
    endcase
    // Ramp flag registered so the output comes from a flop
    st_next.ramp = (st_next.state == OSR_RAMP_UP) || (st_next.state == OSR_RAMP_DOWN);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{state: OSR_OFF, cfg: `OSR_CFG_RESET, cfg_init: 1'b0, sp: '0, pwr: 1'b0, done: 1'b0,
                  ramp: 1'b0, rdata: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign setpoint = st_reg.sp;
  assign power_stage_en = st_reg.pwr;
  assign ramp_active = st_reg.ramp;
  assign shutoff_done = st_reg.done;
endmodule : osr_ramp_ctrl

/* File: test/osr_pm_model.sv */
/*
  Power manager model: master clock tick pulses.
  Assumes clk from the bench.
*/
module osr_pm_model #(
  parameter int PER = 2
) (
  input wire logic clk,
  output logic master_tick = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // One tick per master period
  always @(posedge clk) begin
    n <= (n + 1) % PER;
    master_tick <= (n == PER - 1);
  end
endmodule : osr_pm_model

/* File: test/osr_ramp_ctrl_asserts.sv */
/*
  Port checker of the ramp control.
  Assumes bind onto osr_ramp_ctrl.
*/
module osr_ramp_ctrl_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic master_tick,
  input wire osr_pkg::osr_volt_t target_setpoint,
  input wire osr_pkg::osr_volt_t sensed_output,
  input wire osr_pkg::osr_volt_t setpoint,
  input wire logic power_stage_en,
  input wire logic ramp_active,
  input wire logic shutoff_done
);
  timeunit 1ns;
  timeprecision 1ns;
  import osr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  bit7_zero_a: assert property (!reg_rdata[7]) else $error("bit7");
  cfg_read_a: assert property ((reg_wr && reg_addr == 8'h03) ##1 (!reg_wr && reg_addr == 8'h03)
    |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)}) else $error("readback");
  step_size_a: assert property (setpoint > $past(setpoint)
    |-> setpoint - $past(setpoint) <= 12'h004) else $error("step");
  step_tick_a: assert property ($past(ramp_active) && setpoint != $past(setpoint)
    |-> $past(master_tick, 2)) else $error("tick");
  no_over_a: assert property ($past(ramp_active) && setpoint > $past(setpoint)
    |-> setpoint <= target_setpoint) else $error("overshoot");
  prebias_a: assert property ($rose(power_stage_en)
    |-> setpoint > sensed_output || setpoint == target_setpoint) else $error("prebias");
  done_zero_a: assert property (shutoff_done |-> setpoint == 12'h000 && !power_stage_en)
    else $error("done");
  done_pulse_a: assert property (shutoff_done |=> !shutoff_done) else $error("pulse");
  cover property ($rose(power_stage_en));
  cover property (shutoff_done);
  cover property (reg_wr && reg_addr == 8'h03);
endmodule : osr_ramp_ctrl_asserts
bind osr_ramp_ctrl osr_ramp_ctrl_asserts u_osr_ramp_ctrl_asserts (
  .clk(clk),
  .rst_b(rst_b),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .master_tick(master_tick),
  .target_setpoint(target_setpoint),
  .sensed_output(sensed_output),
  .setpoint(setpoint),
  .power_stage_en(power_stage_en),
  .ramp_active(ramp_active),
  .shutoff_done(shutoff_done)
);

/* File: test/output_slew_ramp_control_tb.sv */
/*
  Bench of the ramp control.
  Assumes the power manager model drives master_tick.
*/
module output_slew_ramp_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import osr_pkg::*;
  logic clk = 0, rst_b = 0, bus_terminator = 0, reg_wr = 0, turn_on = 0, shutoff_expired = 0;
  logic master_tick, power_stage_en, ramp_active, shutoff_done;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  osr_volt_t target_setpoint = 0, sensed_output = 0, setpoint;
  int num_errors = 0, num_checks = 0, cyc = 0, dn = 0, c, f, t, m;
  int tp[7] = '{40, 20, 10, 8, 4, 2, 1};
  logic [31:0] r = 23;
  always #20 clk = ~clk;
  osr_pm_model u_osr_pm_model (.clk(clk), .master_tick(master_tick));
  osr_ramp_ctrl u_osr_ramp_ctrl (
    .clk(clk),
    .rst_b(rst_b),
    .bus_terminator(bus_terminator),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .master_tick(master_tick),
    .turn_on(turn_on),
    .shutoff_expired(shutoff_expired),
    .target_setpoint(target_setpoint),
    .sensed_output(sensed_output),
    .setpoint(setpoint),
    .power_stage_en(power_stage_en),
    .ramp_active(ramp_active),
    .shutoff_done(shutoff_done)
  );
  always @(posedge clk) begin
    cyc++;
    if (shutoff_done === 1'b1) dn++;
    if (cyc > 40000) begin
      num_errors++;
      results();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task chk(input string n, input logic [11:0] s, input logic [11:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk("reg_rdata", {4'h0, reg_rdata}, {4'h0, e});
  endtask : rd
  task go(input bit off);
    @(posedge clk);
    turn_on <= !off;
    shutoff_expired <= off;
    @(posedge clk);
    turn_on <= 1'b0;
    shutoff_expired <= 1'b0;
  endtask : go
  task automatic ramp(input int g, input int k);
    int n, p, v, e, x;
    bit up, w;
    int q[$];
    n = 0;
    #1;
    p = setpoint;
    up = g > p;
    w = power_stage_en;
    v = p;
    // Expected setpoint after every step
    while (v != g) begin
      v = ((g > v ? g - v : v - g) <= 4) ? g : (g > v ? v + 4 : v - 4);
      q.push_back(v);
    end
    e = q.size() * k;
    chk("ramp_active", {11'h0, ramp_active}, 12'h001);
    for (int i = 0; i < 4000 && q.size() > 0; i++) begin
      n += master_tick;
      x = setpoint;
      @(posedge clk);
      #1;
      if (up) begin
        w = w || x > sensed_output;
        chk("power_stage_en", {11'h0, power_stage_en}, {11'h0, w});
      end
      if (setpoint != p) begin
        chk("setpoint", setpoint, 12'(q.pop_front()));
        p = setpoint;
      end
    end
    chk("steps_left", 12'(q.size()), 12'h000);
    chk("ticks", 12'(n >= e - 1 && n <= e + 1), 12'h001);
  endtask : ramp
  task results();
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    for (c = 0; c < 2; c++) begin
      bus_terminator <= c[0];
      rst_b <= 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h03, c ? 8'h0c : 8'h1c);
      @(posedge clk);
    end
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h7f);
    wr(8'h04, 8'h00);
    rd(8'h03, 8'h7f);
    rd(8'h04, 8'h00);
    for (c = 0; c < 8; c++) begin
      @(posedge clk);
      r = xs(r);
      t = 16 + r % 40;
      target_setpoint <= 12'(t);
      sensed_output <= 12'((r >> 8) % t);
      f = 6 - c % 7;
      wr(8'h03, {1'b0, c[2:0], c != 7, f[2:0]});
      go(0);
      ramp(t, tp[c == 7 ? 1 : c]);
      repeat (2) @(posedge clk);
      #1 chk("power_on", {11'h0, power_stage_en}, 12'h001);
      chk("ramp_idle", {11'h0, ramp_active}, 12'h000);
      m = dn;
      go(1);
      if (c != 7) ramp(0, tp[f]);
      repeat (3) @(posedge clk);
      #1 chk("power_off", {11'h0, power_stage_en}, 12'h000);
      chk("setpoint", setpoint, 12'h000);
      chk("done", 12'(dn - m), 12'h001);
      chk("ramp_idle", {11'h0, ramp_active}, 12'h000);
    end
    results();
  end
endmodule : output_slew_ramp_control_tb
